// ### design/adc_fifo_scan_compare_ctrl.v
// Converter FIFO, scan and compare-combine control with an AXI4-Lite slave
`include "adc_fifo_map.vh"

module adc_fifo_scan_compare_ctrl (
  input  wire                     CLK,
  input  wire                     RESET,
  input  wire [9:0]               AWADDR,
  input  wire                     AWVALID,
  output reg                      AWREADY,
  input  wire [31:0]              WDATA,
  input  wire [3:0]               WSTRB,
  input  wire                     WVALID,
  output reg                      WREADY,
  output reg  [1:0]               BRESP,
  output reg                      BVALID,
  input  wire                     BREADY,
  input  wire [9:0]               ARADDR,
  input  wire                     ARVALID,
  output reg                      ARREADY,
  output reg  [31:0]              RDATA,
  output reg  [1:0]               RRESP,
  output reg                      RVALID,
  input  wire                     RREADY,
  input  wire [`RESULT_WIDTH-1:0] ANALOG_VALUE,   // Asynchronous analog sample
  input  wire                     COMPARE_HIT,    // Per-conversion compare match, pin
  output reg                      CONVERSION_COMPLETE,
  output reg                      INTERRUPT_REQUEST
);

  // ---------------------------------------------------------------
  // Registers and queues
  // ---------------------------------------------------------------
  reg [7:0]               fifo_scan_compare_depth_ctrl; // Scan, combine, depth
  reg [7:0]               conv_ctrl;                    // Continuous, irq enable, compare enable
  reg [`CHAN_WIDTH-1:0]   chan_q [0:`FIFO_MAX_LEVEL-1]; // Channel queue
  reg [`RESULT_WIDTH-1:0] res_q  [0:`FIFO_MAX_LEVEL-1]; // Result queue
  reg [3:0]               chan_count;                   // Queued channels
  reg [3:0]               res_count;                    // Stored results
  reg [2:0]               res_rd;                       // Result read pointer
  reg [2:0]               conv_idx;                     // Next channel to convert
  reg                     conversion_complete_flag;
  reg                     hit_any;                      // OR of compare hits
  reg                     hit_all;                      // AND of compare hits
  reg [`RESULT_WIDTH-1:0] single_result;                // Non-FIFO result
  reg [`RESULT_WIDTH-1:0] analog_s1, analog_s2;         // Sample synchroniser
  reg                     hit_s1, hit_s2;               // Hit synchroniser
  reg                     start;                        // Engine start pulse
  reg [`CHAN_WIDTH-1:0]   start_chan;                   // Engine channel

  wire [2:0] fifo_depth       = fifo_scan_compare_depth_ctrl[2:0];
  wire       fifo_scan_enable = fifo_scan_compare_depth_ctrl[`BIT_SCAN_ENABLE];
  wire       compare_combine_select = fifo_scan_compare_depth_ctrl[`BIT_COMBINE_SELECT];
  wire       continuous_conversion  = conv_ctrl[`BIT_CTRL_CONTINUOUS];
  wire       complete_interrupt_enable = conv_ctrl[`BIT_CTRL_IRQ_ENABLE];
  wire       compare_enable   = conv_ctrl[`BIT_CTRL_COMPARE_EN];
  wire       fifo_on          = (fifo_depth != 3'b000);
  wire [3:0] fifo_level       = {1'b0, fifo_depth} + 4'h1;

  // Engine handshake
  wire                     eng_done;
  wire [`RESULT_WIDTH-1:0] eng_result;

  adc_sar_engine u_engine (
    .clk            (CLK),
    .reset          (RESET),
    .start          (start),
    .channel        (start_chan),
    .analog_value   (analog_s2),
    .done           (eng_done),
    .result         (eng_result),
    .result_channel ()
  );

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Two stages before anything reads the pins
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      analog_s1 <= 12'h000;
      analog_s2 <= 12'h000;
      hit_s1    <= 1'b0;
      hit_s2    <= 1'b0;
    end else begin
      analog_s1 <= ANALOG_VALUE;
      analog_s2 <= analog_s1;
      hit_s1    <= COMPARE_HIT;
      hit_s2    <= hit_s1;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  reg        aw_held, w_held;   // Address or data taken, waiting for partner
  reg [9:0]  aw_addr;
  reg [31:0] w_data;
  reg        w_lane0;           // Byte lane 0 strobe
  wire       do_write = aw_held && w_held && !BVALID;
  wire       do_read  = ARVALID && ARREADY;
  wire       chan_push = do_write && w_lane0 && (aw_addr == `ADDR_CHAN_SELECT);
  wire       res_pop   = do_read && (ARADDR == `ADDR_RESULT);

  // Write address and data taken in either order, response after both
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      AWREADY <= 1'b1;
      WREADY  <= 1'b1;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 10'h000;
      w_data  <= 32'h00000000;
      w_lane0 <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= 2'b00;
      fifo_scan_compare_depth_ctrl <= `FIFO_CTRL_RESET;
      conv_ctrl <= `CONV_CTRL_RESET;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
        AWREADY <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_held  <= 1'b1;
        w_data  <= WDATA;
        w_lane0 <= WSTRB[0];
        WREADY  <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        BVALID  <= 1'b1;
        BRESP   <= 2'b00;
        if (aw_addr == `ADDR_FIFO_CTRL) begin
          if (w_lane0)
            fifo_scan_compare_depth_ctrl <= w_data[7:0] & `FIFO_CTRL_WMASK;
        end else if (aw_addr == `ADDR_CONV_CTRL) begin
          if (w_lane0)
            conv_ctrl <= {5'h00, w_data[2:0]};
        end else if (aw_addr == `ADDR_CHAN_SELECT || aw_addr == `ADDR_RESULT ||
                     aw_addr == `ADDR_STATUS) begin
          BRESP <= 2'b00;
        end else begin
          BRESP <= 2'b10;  // Unmapped address
        end
      end
      if (BVALID && BREADY) begin
        BVALID  <= 1'b0;
        AWREADY <= 1'b1;
        WREADY  <= 1'b1;
      end
    end
  end

  // Reads answer one cycle after the address is taken
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ARREADY <= 1'b1;
      RVALID  <= 1'b0;
      RDATA   <= 32'h00000000;
      RRESP   <= 2'b00;
    end else begin
      if (do_read) begin
        ARREADY <= 1'b0;
        RVALID  <= 1'b1;
        RRESP   <= 2'b00;
        if (ARADDR == `ADDR_FIFO_CTRL) begin
          RDATA <= {24'h000000, fifo_scan_compare_depth_ctrl & `FIFO_CTRL_WMASK};
        end else if (ARADDR == `ADDR_RESULT) begin
          RDATA <= {20'h00000, fifo_on ? res_q[res_rd] : single_result};
        end else if (ARADDR == `ADDR_STATUS) begin
          // Queued channels in [9:6], request in [1], flag in [0]
          RDATA <= {22'h000000, chan_count, 4'h0, INTERRUPT_REQUEST, conversion_complete_flag};
        end else if (ARADDR == `ADDR_CONV_CTRL) begin
          RDATA <= {24'h000000, conv_ctrl};
        end else if (ARADDR == `ADDR_CHAN_SELECT) begin
          RDATA <= {27'h0000000, start_chan};
        end else begin
          RDATA <= 32'h00000000;
          RRESP <= 2'b10;  // Unmapped address
        end
      end else if (RVALID && RREADY) begin
        RVALID  <= 1'b0;
        ARREADY <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;  // Waiting for channels
  localparam [2:0] ST_CONV = 3'b010;  // Engine running
  localparam [2:0] ST_NEXT = 3'b100;  // Deciding the next step
  reg [2:0] state;

  // Hits merged so far, including one arriving with this completion
  wire any_now = hit_any | hit_s2;
  wire all_now = hit_all & hit_s2;
  // Combine choice only matters in FIFO mode
  wire combine_ok = !compare_enable ? 1'b1 :
                    (fifo_on ? (compare_combine_select ? all_now : any_now) : hit_s2);
  wire res_full_next = (res_count + 4'h1) >= fifo_level;
  wire sw_clear = res_pop || chan_push;  // Result reads and channel writes clear completion
  wire pop_ok   = res_pop && fifo_on && (res_count != 4'h0);  // Pop of a stored result

  // Queues, completion and conversion sequencing
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state <= ST_IDLE;
      chan_count <= 4'h0;
      res_count  <= 4'h0;
      res_rd     <= 3'h0;
      conv_idx   <= 3'h0;
      conversion_complete_flag <= 1'b0;
      hit_any    <= 1'b0;
      hit_all    <= 1'b1;
      single_result <= 12'h000;
      start      <= 1'b0;
      start_chan <= 5'h00;
      CONVERSION_COMPLETE <= 1'b0;
      INTERRUPT_REQUEST   <= 1'b0;
    end else begin
      start <= 1'b0;
      CONVERSION_COMPLETE <= conversion_complete_flag;
      // Flag with enable drives the request
      INTERRUPT_REQUEST <= conversion_complete_flag & complete_interrupt_enable;
      if (sw_clear)
        conversion_complete_flag <= 1'b0;
      if (pop_ok) begin
        res_rd    <= res_rd + 3'h1;
        res_count <= res_count - 4'h1;
      end
      if (chan_push && fifo_on && chan_count < fifo_level && state == ST_IDLE) begin
        chan_q[chan_count[2:0]] <= w_data[`CHAN_WIDTH-1:0];
        chan_count <= chan_count + 4'h1;
      end
      case (state)
        ST_IDLE: begin
          if (!fifo_on && chan_push) begin
            start      <= 1'b1;
            start_chan <= w_data[`CHAN_WIDTH-1:0];
            hit_any    <= 1'b0;
            hit_all    <= 1'b1;
            state      <= ST_CONV;
          end else if (fifo_on && chan_count >= fifo_level && !chan_push) begin
            // Begin only once channel queue holds a full level
            start      <= 1'b1;
            start_chan <= chan_q[0];
            conv_idx   <= 3'h1;
            res_count  <= 4'h0;
            res_rd     <= 3'h0;
            hit_any    <= 1'b0;
            hit_all    <= 1'b1;
            state      <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (eng_done) begin
            hit_any <= any_now;
            hit_all <= all_now;
            if (!fifo_on) begin
              single_result <= eng_result;
              if (combine_ok)
                conversion_complete_flag <= 1'b1;
              state <= ST_NEXT;
            end else begin
              res_q[res_count[2:0] + res_rd] <= eng_result;
              // A pop in the same cycle cancels the count step
              res_count <= pop_ok ? res_count : res_count + 4'h1;
              if (res_full_next) begin
                // Flag only when the whole set is stored
                // OR or AND of compare hits gates the flag
                if (combine_ok)
                  conversion_complete_flag <= 1'b1;
                state <= ST_NEXT;
              end else begin
                // Scan mode keeps the first queued channel
                start      <= 1'b1;
                start_chan <= fifo_scan_enable ? chan_q[0] : chan_q[conv_idx];
                conv_idx   <= conv_idx + 3'h1;
              end
            end
          end
        end
        ST_NEXT: begin
          if (continuous_conversion) begin
            // Next run starts the cycle after completion sets, from the first queued channel in FIFO mode
            start    <= 1'b1;
            conv_idx <= 3'h1;
            hit_any  <= 1'b0;
            hit_all  <= 1'b1;
            if (fifo_on) begin
              start_chan <= chan_q[0];
              res_count  <= 4'h0;
              res_rd     <= 3'h0;
            end
            state <= ST_CONV;
          end else begin
            chan_count <= 4'h0;  // Set consumed; software queues again
            state      <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // adc_fifo_scan_compare_ctrl

// ### common/adc_fifo_map.vh
// Offsets, fields, reset values and timing counts for the converter FIFO control
`ifndef ADC_FIFO_MAP_VH
`define ADC_FIFO_MAP_VH

// ---------------------------------------------------------------
// Register byte addresses (printed offset index times four)
// ---------------------------------------------------------------
`define IDX_FIFO_CTRL        8'h13
`define ADDR_FIFO_CTRL       10'h04c
`define ADDR_CHAN_SELECT     10'h100
`define ADDR_RESULT          10'h104
`define ADDR_STATUS          10'h108
`define ADDR_CONV_CTRL       10'h10c

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define BIT_SCAN_ENABLE      6
`define BIT_COMBINE_SELECT   5
`define FIFO_CTRL_WMASK      8'h67
`define CHAN_WIDTH           5
`define RESULT_WIDTH         12
`define FIFO_MAX_LEVEL       8
`define BIT_STAT_COMPLETE    0
`define BIT_STAT_IRQ         1
`define BIT_CTRL_CONTINUOUS  0
`define BIT_CTRL_IRQ_ENABLE  1
`define BIT_CTRL_COMPARE_EN  2

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define FIFO_CTRL_RESET      8'h00
`define CONV_CTRL_RESET      8'h00
`define CONV_TIME_NS         160
`define CLK_PERIOD_NS        10
`define CONV_CYCLES          8'h10   // 160 ns at a 10 ns clock

`endif

// ### design/adc_sar_engine.v
// Stand-in converter engine: fixed conversion time, result from the analog input
`include "adc_fifo_map.vh"

module adc_sar_engine (
  input  wire                       clk,
  input  wire                       reset,
  input  wire                       start,        // One-cycle start pulse
  input  wire [`CHAN_WIDTH-1:0]     channel,      // Channel to sample
  input  wire [`RESULT_WIDTH-1:0]   analog_value, // Already synchronised sample
  output reg                        done,         // One-cycle completion pulse
  output reg  [`RESULT_WIDTH-1:0]   result,       // Converted value
  output reg  [`CHAN_WIDTH-1:0]     result_channel
);

  // ---------------------------------------------------------------
  // Conversion timer
  // ---------------------------------------------------------------
  localparam [7:0] CONV_LAST = `CONV_CYCLES - 8'h01;
  reg [7:0] count;       // Cycles spent in current conversion
  reg       busy;        // Conversion running

  // Counts a fixed time; a real array would go through successive approximation
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      count          <= 8'h00;
      busy           <= 1'b0;
      done           <= 1'b0;
      result         <= 12'h000;
      result_channel <= 5'h00;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy           <= 1'b1;
        count          <= 8'h00;
        result_channel <= channel;
      end else if (busy) begin
        if (count == CONV_LAST) begin
          // Sample taken at the end of the window
          busy   <= 1'b0;
          done   <= 1'b1;
          result <= analog_value;
        end else begin
          count <= count + 8'h01;
        end
      end
    end
  end

endmodule // adc_sar_engine

// ### bench/adc_fifo_monitor.sv
// Port-level checker for the converter FIFO control block
`include "adc_fifo_map.vh"

module adc_fifo_monitor (
  input wire        CLK,
  input wire        RESET,
  input wire        AWVALID,
  input wire        AWREADY,
  input wire        WVALID,
  input wire        WREADY,
  input wire        BVALID,
  input wire [9:0]  ARADDR,
  input wire        ARVALID,
  input wire        ARREADY,
  input wire [31:0] RDATA,
  input wire [1:0]  RRESP,
  input wire        RVALID,
  input wire        CONVERSION_COMPLETE,
  input wire        INTERRUPT_REQUEST
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Read address tracking
  // ------------------------------------------------------------
  reg  [9:0] rd_addr;  // Address of the read in flight
  wire       mapped;   // Read hits a decoded register
  assign mapped = rd_addr == `ADDR_FIFO_CTRL || rd_addr == `ADDR_CHAN_SELECT ||
                  rd_addr == `ADDR_RESULT || rd_addr == `ADDR_STATUS ||
                  rd_addr == `ADDR_CONV_CTRL;
  // Capture at the address handshake, data follows a cycle later
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rd_addr <= 10'h000;
    end else if (ARVALID && ARREADY) begin
      rd_addr <= ARADDR;
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_reset_idle: assert property ($fell(RESET) |->
    !BVALID && !RVALID && !CONVERSION_COMPLETE)
    else $error("response or flag active after reset");
  a_irq_needs_flag: assert property (INTERRUPT_REQUEST |-> CONVERSION_COMPLETE)
    else $error("interrupt without completion");
  a_aw_busy: assert property (AWVALID && AWREADY |=> !AWREADY)
    else $error("write address ready while busy");
  a_ar_busy: assert property (ARVALID && ARREADY |=> !ARREADY)
    else $error("read address ready while busy");
  a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |->
    ##[1:2] BVALID)
    else $error("write response late");
  a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read data late");
  a_reserved_zero: assert property (RVALID && rd_addr == `ADDR_FIFO_CTRL |->
    RDATA[31:7] == 25'h0 && RDATA[4:3] == 2'h0)
    else $error("reserved control bits not zero");
  a_unmapped_err: assert property (RVALID && !mapped |->
    RRESP == 2'h2 && RDATA == 32'h0)
    else $error("unmapped read not refused");
  a_mapped_okay: assert property (RVALID && mapped |-> RRESP == 2'h0)
    else $error("mapped read refused");
endmodule // adc_fifo_monitor

bind adc_fifo_scan_compare_ctrl adc_fifo_monitor u_mon (.CLK(CLK), .RESET(RESET),
  .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID),
  .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
  .RVALID(RVALID), .CONVERSION_COMPLETE(CONVERSION_COMPLETE),
  .INTERRUPT_REQUEST(INTERRUPT_REQUEST));

// ### bench/adc_cpu_model.sv
// Software side model: bus master issuing register cycles
module adc_cpu_model (
  input  wire         clk,
  output logic [9:0]  awaddr,
  output logic        awvalid,
  input  wire         awready,
  output logic [31:0] wdata,
  output logic [3:0]  wstrb,
  output logic        wvalid,
  input  wire         wready,
  input  wire         bvalid,
  output logic        bready,
  output logic [9:0]  araddr,
  output logic        arvalid,
  input  wire         arready,
  input  wire  [31:0] rdata,
  input  wire  [1:0]  rresp,
  input  wire         rvalid,
  output logic        rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // Each channel is released at its own handshake
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!((!awvalid || awready) && (!wvalid || wready)));
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
  endtask

  // Read cycle, data and response taken at the handshake edge
  task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule // adc_cpu_model

// ### bench/adc_fifo_scan_compare_ctrl_tb_top.sv
// Self-checking bench for the converter FIFO control block
`include "adc_fifo_map.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end

module adc_fifo_scan_compare_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, reset, hit, done, irq;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [9:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d, tmp;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [11:0] av;              // Analog level held per set
  bit          ok;
  integer      failures, check_count, seed, k;

  adc_fifo_scan_compare_ctrl u_dut (.CLK(clk), .RESET(reset), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
    .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready), .ANALOG_VALUE(av), .COMPARE_HIT(hit), .CONVERSION_COMPLETE(done),
    .INTERRUPT_REQUEST(irq));
  adc_cpu_model u_cpu (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // ------------------------------------------------------------
  // Clock, expectations and helpers
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Queue level from the depth field, zero means single shot
  function automatic [3:0] lvl(input [2:0] f);
    lvl = (f == 3'h0) ? 4'h1 : {1'b0, f} + 4'h1;
  endfunction
  // Reserved control bits read back as zero
  function automatic [31:0] ctrl_rb(input [31:0] v);
    ctrl_rb = {25'h0, v[6:5], 2'b00, v[2:0]};
  endfunction
  // Bounded wait on the completion pin
  task automatic wait_done(input integer lim, output bit got);
    got = 1'b0;
    repeat (lim) begin
      @(posedge clk);
      if (done === 1'b1) begin
        got = 1'b1;
        break;
      end
    end
  endtask
  // Program depth, queue channels, wait for the set
  task automatic run_set(input [31:0] ctl, output bit got);
    logic [3:0] n;
    integer     i;
    n = lvl(ctl[2:0]);
    u_cpu.wr(`ADDR_FIFO_CTRL, ctl);
    for (i = 0; i < n - 1; i++) u_cpu.wr(`ADDR_CHAN_SELECT, i);
    // Partial queue must not start anything
    if (n > 4'h1) begin
      u_cpu.rd(`ADDR_STATUS, d, r);
      `CHK(d[9:6], n - 4'h1)
      repeat (40) @(posedge clk);
      `CHK(done, 1'b0)
    end
    u_cpu.wr(`ADDR_CHAN_SELECT, {28'h0, n - 4'h1});
    wait_done(n * 20 + 40, got);
  endtask
  // Pop a number of results, all from the held level
  task automatic drain(input [3:0] n);
    integer i;
    for (i = 0; i < n; i++) begin
      u_cpu.rd(`ADDR_RESULT, d, r);
      `CHK(d, {20'h0, av})
    end
  endtask
  // Verdict and end of run
  task automatic results;
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Watchdog, sized well above the longest scenario
  // ------------------------------------------------------------
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    results();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {reset, hit, av, failures, check_count} = {1'b1, 1'b0, 12'h0, 32'h0, 32'h0};
    seed = 28402;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    // Reset state of control, conversion control and status
    for (k = 0; k < 3; k++) begin
      u_cpu.rd(k == 0 ? `ADDR_FIFO_CTRL : k == 1 ? `ADDR_CONV_CTRL : `ADDR_STATUS, d, r);
      `CHK(d, 32'h0)
    end
    // Unmapped place is refused
    u_cpu.rd(10'h200, d, r);
    `CHK({r, d}, {2'b10, 32'h0})
    u_cpu.wr(10'h200, 32'h5a);
    `CHK(bresp, 2'b10)
    // All ones first, then random patterns
    for (k = 0; k < 5; k++) begin
      tmp = (k == 0) ? 32'hff : $random(seed);
      u_cpu.wr(`ADDR_FIFO_CTRL, tmp);
      `CHK(bresp, 2'b00)
      u_cpu.rd(`ADDR_FIFO_CTRL, d, r);
      `CHK(d, ctrl_rb(tmp))
    end
    // Every depth code, interrupt enabled, random combine bit
    u_cpu.wr(`ADDR_CONV_CTRL, 32'h2);
    for (k = 0; k < 8; k++) begin
      tmp = $random(seed);
      av <= tmp[11:0];
      run_set({26'h0, tmp[12], 2'b00, k[2:0]}, ok);
      if (k == 0) `CHK(ok, 1'b1)
      `CHK(ok, 1'b1)
      `CHK(irq, 1'b1)
      // Without scan the last queued channel is converted last
      u_cpu.rd(`ADDR_CHAN_SELECT, d, r);
      `CHK(d, {28'h0, lvl(k[2:0]) - 4'h1})
      drain(lvl(k[2:0]));
    end
    // Compare combining with hits present
    u_cpu.wr(`ADDR_CONV_CTRL, 32'h6);
    hit <= 1'b1;
    run_set(32'h21, ok);
    `CHK(ok, 1'b1)
    drain(4'h2);
    run_set(32'h01, ok);
    `CHK(ok, 1'b1)
    drain(4'h2);
    run_set(32'h20, ok);
    `CHK(ok, 1'b1)
    drain(4'h1);
    // Hit flips every 6 cycles; conversions 18 apart see opposite hits
    for (k = 0; k < 2; k++) begin
      fork
        repeat (40) begin
          repeat (6) @(posedge clk);
          hit <= ~hit;
        end
        run_set(k == 0 ? 32'h21 : 32'h01, ok);
      join
      if (k == 0) `CHK(ok, 1'b0)
      else `CHK(ok, 1'b1)
      drain(4'h2);
    end
    // No hit at all: the set must not complete
    hit <= 1'b0;
    run_set(32'h01, ok);
    `CHK(ok, 1'b0)
    // Reset after the failed set clears the control register
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    u_cpu.rd(`ADDR_FIFO_CTRL, d, r);
    `CHK(d, 32'h0)
    // Scan mode with continuous conversion
    u_cpu.wr(`ADDR_CONV_CTRL, 32'h1);
    run_set(32'h43, ok);
    `CHK(ok, 1'b1)
    drain(4'h4);
    // Mid-set, the converted channel is still the first queued one
    repeat (25) @(posedge clk);
    u_cpu.rd(`ADDR_CHAN_SELECT, d, r);
    `CHK(d, 32'h0)
    wait_done(200, ok);
    `CHK(ok, 1'b1)
    results();
  end
endmodule // adc_fifo_scan_compare_ctrl_tb_top
